// *** common/smrs_pkg.sv ***
// Constants and types shared by the stop-mode and reset-source block
package smrs_pkg;

	// ==========================================================
	// Register addresses on the special function register port
	localparam logic [7:0] SMRS_ADDR_POWER_MODE   = 8'h87;
	localparam logic [7:0] SMRS_ADDR_RESET_SOURCE = 8'hef;

	// ==========================================================
	// Field positions
	localparam int SMRS_PM_IDLE_BIT  = 0;
	localparam int SMRS_PM_STOP_BIT  = 1;
	localparam int SMRS_RS_PIN_BIT   = 0;
	localparam int SMRS_RS_POR_BIT   = 1;
	localparam int SMRS_RS_CLOSS_BIT = 2;
	localparam int SMRS_RS_CMP_BIT   = 5;
	localparam int SMRS_RS_CNV_BIT   = 6;

	// ==========================================================
	// Reset values
	localparam logic [7:0] SMRS_POWER_MODE_RST   = 8'h00;
	localparam logic [7:0] SMRS_RESET_SOURCE_RST = 8'h00;
	localparam logic [7:0] SMRS_BYTE_ZERO        = 8'h00;

	// ==========================================================
	// Timing
	localparam int SMRS_CLK_HZ            = 20_000_000;
	localparam int SMRS_SUPPLY_TIMEOUT_MS = 100;
	localparam int SMRS_PIN_HOLD_CYC      = 12;
	localparam int SMRS_CNT_W             = 22;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SMRS_ST_RUN,
		SMRS_ST_RESET
	} smrs_state_t;

	// One bit for each reset cause
	typedef struct packed {
		logic supply;
		logic pin;
		logic closs;
		logic cmp;
		logic cnv;
	} smrs_cause_t;

	// Asynchronous inputs, packed together for the synchroniser
	typedef struct packed {
		logic supply_ok;
		logic mon_en;
		logic rst_pin_n;
		logic closs_trip;
		logic cmp_below;
		logic cnv_n;
		logic osc_stable;
	} smrs_async_t;

	localparam smrs_async_t SMRS_ASYNC_RST = '{
		supply_ok:  1'b0,
		mon_en:     1'b0,
		rst_pin_n:  1'b1,
		closs_trip: 1'b0,
		cmp_below:  1'b0,
		cnv_n:      1'b1,
		osc_stable: 1'b0
	};

	// Special function register access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} smrs_sfr_req_t;

endpackage

// *** verilog/smrs_core.sv ***
// Stop mode control and reset-source merging with cause flags
`timescale 1ns/1ps

// Notes on behaviour
// - Writing stop bit enters stop after instruction
// - Stop halts CPU and oscillators
// - Only a reset leaves stop; restart 0x0000
// - Reset halts execution, resets registers, ports, timers
// - Reset keeps data memory; stack pointer reinitialised
// - Port latches high within four cycles
// - Exit clears PC, slow oscillator, watchdog longest
// - Supply monitor holds reset, pin low 100 ms
// - Monitor-enable pin gates supply-monitor reset
// - Power-on sets power flag; others clear it
// - Supply drop resets; recovery like power-on
// - Pin low resets; 12 cycles then pin flag
// - Clock loss resets; flag bit 2; pin untouched
// - Comparator reset enable bit 5; flag reads one
// - Convert input low resets when bit 6 set
// - Reset-routed convert input starts no conversion
module smrs_core
	import smrs_pkg::*;
#(
	parameter int SUPPLY_TIMEOUT_CYC = SMRS_SUPPLY_TIMEOUT_MS * (SMRS_CLK_HZ / 1000),
	parameter int PIN_HOLD_CYC       = SMRS_PIN_HOLD_CYC
) (
	// Clock and power-on reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// Special function register port
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Processor handshake
	input  wire logic       instr_done,
	input  wire logic       irq_wake,
	// Analog and pin inputs, asynchronous
	input  wire logic       supply_ok,
	input  wire logic       supply_monitor_enable_pin,
	input  wire logic       rst_pin_n_i,
	input  wire logic       clock_loss_trip,
	input  wire logic       comparator_below,
	input  wire logic       convert_start_input_n,
	input  wire logic       osc_stable,
	// Reset pin drive, open drain
	output logic            rst_pin_o,
	output logic            rst_pin_oe,
	// System controls
	output logic            sys_rst,
	output logic            cpu_halt,
	output logic            osc_stop,
	output logic            idle_mode,
	output logic            port_latch_force,
	output logic            irq_timer_disable,
	output logic            exec_enable,
	output logic            reset_exit,
	output logic            second_converter_start
);

	// ==========================================================
	// Elaboration checks
	// The shared counter must reach the longest hold, the pin hold included
	if (SUPPLY_TIMEOUT_CYC < 1 || SUPPLY_TIMEOUT_CYC >= (1 << SMRS_CNT_W)) begin : g_bad_supply
		$error("SUPPLY_TIMEOUT_CYC out of counter range");
	end
	if (PIN_HOLD_CYC < 1 || PIN_HOLD_CYC > SUPPLY_TIMEOUT_CYC) begin : g_bad_hold
		$error("PIN_HOLD_CYC out of range");
	end

	localparam logic [SMRS_CNT_W-1:0] SUP_LAST = SMRS_CNT_W'(SUPPLY_TIMEOUT_CYC - 1);
	localparam logic [SMRS_CNT_W-1:0] PIN_LAST = SMRS_CNT_W'(PIN_HOLD_CYC - 1);
	localparam logic [SMRS_CNT_W-1:0] CNT_ONE  = SMRS_CNT_W'(1);

	// ==========================================================
	// State of the block
	typedef struct packed {
		smrs_async_t            sync1;
		smrs_async_t            sync2;
		smrs_state_t            state;
		smrs_cause_t            cause;
		logic [SMRS_CNT_W-1:0]  cnt;
		logic                   stop_pend;
		logic                   idle_pend;
		logic                   stop;
		logic                   idle;
		logic                   por_flag;
		logic                   pin_flag;
		logic                   closs_bit;
		logic                   cmp_bit;
		logic                   cnv_bit;
		logic [7:0]             rdata;
		logic                   rst_pin_oe;
		logic                   oe_seen1;
		logic                   oe_seen2;
		logic                   sys_rst;
		logic                   cpu_halt;
		logic                   osc_stop;
		logic                   port_force;
		logic                   exec_en;
		logic                   exit_pulse;
		logic                   cnv_start;
	} smrs_reg_t;

	// Power-on state: in reset, caused by the supply, pin driven low
	localparam smrs_reg_t REG_RST = '{
		sync1:      SMRS_ASYNC_RST,
		sync2:      SMRS_ASYNC_RST,
		state:      SMRS_ST_RESET,
		cause:      '{supply: 1'b1, default: 1'b0},
		cnt:        '0,
		rdata:      SMRS_BYTE_ZERO,
		rst_pin_oe: 1'b1,
		sys_rst:    1'b1,
		cpu_halt:   1'b1,
		port_force: 1'b1,
		default:    1'b0
	};

	smrs_reg_t     s_q;
	smrs_reg_t     s_d;
	smrs_async_t   async_in;
	smrs_sfr_req_t req;
	smrs_cause_t   src;
	logic          any_src;
	logic          wr_pm;
	logic          wr_rs;
	logic          hold_done;
	logic          own_drive;

	// ==========================================================
	// Input gathering
	assign async_in = '{
		supply_ok:  supply_ok,
		mon_en:     supply_monitor_enable_pin,
		rst_pin_n:  rst_pin_n_i,
		closs_trip: clock_loss_trip,
		cmp_below:  comparator_below,
		cnv_n:      convert_start_input_n,
		osc_stable: osc_stable
	};
	assign req = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_d = s_q;
		// Two-stage synchroniser; only the second stage is read below
		s_d.sync1 = async_in;
		s_d.sync2 = s_q.sync1;

		// Own pin drive, delayed to line up with the synchronised pin level
		s_d.oe_seen1 = s_q.rst_pin_oe;
		s_d.oe_seen2 = s_q.oe_seen1;
		own_drive    = s_q.rst_pin_oe | s_q.oe_seen1 | s_q.oe_seen2;

		src.supply = s_q.sync2.mon_en & ~s_q.sync2.supply_ok;
		// pin low resets; our own pull-down is no cause, else a
		// supply reset would keep itself alive through the pin forever
		src.pin    = ~s_q.sync2.rst_pin_n & ~own_drive;
		src.closs  = s_q.closs_bit & s_q.sync2.closs_trip;
		src.cmp    = s_q.cmp_bit & s_q.sync2.cmp_below;
		src.cnv    = s_q.cnv_bit & ~s_q.sync2.cnv_n;
		any_src    = |src;

		wr_pm = req.wr && (req.addr == SMRS_ADDR_POWER_MODE);
		wr_rs = req.wr && (req.addr == SMRS_ADDR_RESET_SOURCE);
		hold_done = s_q.cause.supply ? (s_q.cnt >= SUP_LAST) : (s_q.cnt >= PIN_LAST);
		s_d.exit_pulse = 1'b0;

		unique case (s_q.state)
			SMRS_ST_RUN: begin
				// mode bits act on write, never stored for read-back
				if (wr_pm && req.wdata[SMRS_PM_STOP_BIT])
					s_d.stop_pend = 1'b1;
				if (wr_pm && req.wdata[SMRS_PM_IDLE_BIT])
					s_d.idle_pend = 1'b1;
				// stop takes effect once the writing instruction completes
				if (s_q.stop_pend && instr_done) begin
					s_d.stop      = 1'b1;
					s_d.stop_pend = 1'b0;
				end
				if (s_q.idle_pend && instr_done) begin
					s_d.idle      = 1'b1;
					s_d.idle_pend = 1'b0;
				end
				// Idle ends on an interrupt; stop does not
				if (s_q.idle && irq_wake)
					s_d.idle = 1'b0;
				// Enables: bit 2 arms clock-loss, bits 5 and 6 arm sources
				if (wr_rs) begin
					s_d.closs_bit = req.wdata[SMRS_RS_CLOSS_BIT];
					// comparator assumed settled before this write
					s_d.cmp_bit   = req.wdata[SMRS_RS_CMP_BIT];
					// routing assumed done before this write
					s_d.cnv_bit   = req.wdata[SMRS_RS_CNV_BIT];
				end
				if (any_src) begin
					s_d.state = SMRS_ST_RESET;
					s_d.cause = src;
					s_d.cnt   = '0;
				end
			end
			SMRS_ST_RESET: begin
				// mode bits and pending requests return to reset values while held
				s_d.stop      = 1'b0;
				s_d.idle      = 1'b0;
				s_d.stop_pend = 1'b0;
				s_d.idle_pend = 1'b0;
				s_d.cause     = s_q.cause | src;
				if (any_src) begin
					s_d.cnt = '0;
				end else if (hold_done) begin
					s_d.state      = SMRS_ST_RUN;
					s_d.exit_pulse = 1'b1;
					s_d.cnt        = '0;
					// power flag from supply, cleared by any other
					s_d.por_flag   = s_q.cause.supply;
					s_d.pin_flag   = s_q.cause.pin & ~s_q.cause.supply;
					s_d.closs_bit  = s_q.cause.closs & ~s_q.cause.supply;
					// comparator bit reads one after its reset
					s_d.cmp_bit    = s_q.cause.cmp & ~s_q.cause.supply;
					// convert bit reads one after its reset
					s_d.cnv_bit    = s_q.cause.cnv & ~s_q.cause.supply;
				end else begin
					s_d.cnt = s_q.cnt + CNT_ONE;
				end
			end
			// Unused state code: fall back into reset
			default: s_d.state = SMRS_ST_RESET;
		endcase

		// Read data; mode bits and reserved bits read as zero
		if (req.rd && req.addr == SMRS_ADDR_RESET_SOURCE) begin
			s_d.rdata = SMRS_RESET_SOURCE_RST;
			s_d.rdata[SMRS_RS_PIN_BIT]   = s_q.pin_flag;
			s_d.rdata[SMRS_RS_POR_BIT]   = s_q.por_flag;
			s_d.rdata[SMRS_RS_CLOSS_BIT] = s_q.closs_bit;
			s_d.rdata[SMRS_RS_CMP_BIT]   = s_q.cmp_bit;
			s_d.rdata[SMRS_RS_CNV_BIT]   = s_q.cnv_bit;
		end else if (req.rd) begin
			// power mode register always reads zero
			s_d.rdata = SMRS_POWER_MODE_RST;
		end

		// pin driven low only for supply resets; leave it
		s_d.rst_pin_oe = (s_d.state == SMRS_ST_RESET) && s_d.cause.supply;
		s_d.sys_rst    = (s_d.state == SMRS_ST_RESET);
		s_d.cpu_halt   = s_d.sys_rst | s_d.stop | s_d.idle;
		s_d.osc_stop   = s_d.stop;
		// latches forced high on the same edge as sys_rst, well inside four
		s_d.port_force = s_d.sys_rst;
		// execution from 0x0000 waits for a stable clock
		s_d.exec_en    = ~s_d.sys_rst & ~s_d.cpu_halt & s_q.sync2.osc_stable;
		// reset-routed convert input starts no conversion
		s_d.cnv_start  = ~s_d.cnv_bit & ~s_q.sync2.cnv_n;
	end

	// ==========================================================
	// State register
	// no memory clear here: data memory is left alone by reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= REG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs straight from the state register, except rst_pin_o tied low
	assign sfr_rdata              = s_q.rdata;
	assign rst_pin_o              = 1'b0;
	assign rst_pin_oe             = s_q.rst_pin_oe;
	// halt, register reset, timers and interrupts off
	assign sys_rst                = s_q.sys_rst;
	assign irq_timer_disable      = s_q.sys_rst;
	assign cpu_halt               = s_q.cpu_halt;
	assign osc_stop               = s_q.osc_stop;
	assign idle_mode              = s_q.idle;
	assign port_latch_force       = s_q.port_force;
	assign exec_enable            = s_q.exec_en;
	// exit pulse clears PC, slow oscillator, watchdog longest
	assign reset_exit             = s_q.exit_pulse;
	assign second_converter_start = s_q.cnv_start;

endmodule

// *** sim/smrs_core_asserts.sv ***
// Port checks for the stop and reset-source block
`timescale 1ns/1ps
module smrs_core_asserts
	import smrs_pkg::*;
#(
	parameter int PIN_HOLD_CYC = SMRS_PIN_HOLD_CYC
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       arst_n,
	// Register port
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       instr_done,
	// Pins
	input wire logic       supply_ok,
	input wire logic       supply_monitor_enable_pin,
	input wire logic       rst_pin_n_i,
	input wire logic       rst_pin_o,
	input wire logic       rst_pin_oe,
	// Controls
	input wire logic       sys_rst,
	input wire logic       cpu_halt,
	input wire logic       osc_stop,
	input wire logic       port_latch_force,
	input wire logic       irq_timer_disable,
	input wire logic       exec_enable,
	input wire logic       reset_exit
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ====
	// Stop request is a write of the stop bit, then instruction end
	sequence s_stop_wr;
		sfr_wr && !sys_rst && sfr_addr == SMRS_ADDR_POWER_MODE && sfr_wdata[SMRS_PM_STOP_BIT];
	endsequence
	sequence s_stop_req;
		s_stop_wr ##1 instr_done;
	endsequence
	chk_stop_entry: assert property (s_stop_req |=> osc_stop && cpu_halt)
		else $error("stop not entered");
	chk_stop_hold: assert property ($fell(osc_stop) |-> sys_rst)
		else $error("stop left without reset");
	chk_mode_read: assert property (sfr_rd && sfr_addr == SMRS_ADDR_POWER_MODE |=>
		sfr_rdata == SMRS_BYTE_ZERO) else $error("power mode read not zero");
	chk_halt_state: assert property (sys_rst[*2] |-> cpu_halt && port_latch_force &&
		irq_timer_disable && !exec_enable) else $error("reset state incomplete");
	chk_exit_pulse: assert property ($fell(sys_rst) |-> reset_exit ##1 !reset_exit)
		else $error("exit pulse wrong");
	chk_exec_gate: assert property (exec_enable |-> !sys_rst && !osc_stop)
		else $error("fetch while halted");
	chk_oe_reset: assert property (rst_pin_oe |-> sys_rst && !rst_pin_o)
		else $error("pin driven outside reset");
	chk_supply_drop: assert property ((!supply_ok && supply_monitor_enable_pin)[*4]
		|-> sys_rst && rst_pin_oe) else $error("supply drop missed");
	chk_pin_enter: assert property ((!rst_pin_n_i)[*4] |-> sys_rst)
		else $error("pin low missed");
	// Slow exits come from the supply timeout, so skip those
	chk_pin_hold: assert property ($fell(sys_rst) && !$past(rst_pin_oe) |->
		$past(rst_pin_n_i, PIN_HOLD_CYC)) else $error("pin hold too short");
endmodule
bind smrs_core smrs_core_asserts #(.PIN_HOLD_CYC(PIN_HOLD_CYC)) u_chk (
	.mclk                      (mclk),
	.arst_n                    (arst_n),
	.sfr_wr                    (sfr_wr),
	.sfr_rd                    (sfr_rd),
	.sfr_addr                  (sfr_addr),
	.sfr_wdata                 (sfr_wdata),
	.sfr_rdata                 (sfr_rdata),
	.instr_done                (instr_done),
	.supply_ok                 (supply_ok),
	.supply_monitor_enable_pin (supply_monitor_enable_pin),
	.rst_pin_n_i               (rst_pin_n_i),
	.rst_pin_o                 (rst_pin_o),
	.rst_pin_oe                (rst_pin_oe),
	.sys_rst                   (sys_rst),
	.cpu_halt                  (cpu_halt),
	.osc_stop                  (osc_stop),
	.port_latch_force          (port_latch_force),
	.irq_timer_disable         (irq_timer_disable),
	.exec_enable               (exec_enable),
	.reset_exit                (reset_exit)
);

// *** sim/smrs_ext_model.sv ***
// Reset pin wiring and oscillator start-up model
`timescale 1ns/1ps
module smrs_ext_model (
	// Clock and power
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic rst_pin_oe,
	// Levels toward the block
	output logic      rst_pin_n_i,
	output logic      osc_stable
);
	logic       pin_low = 1'b0;
	logic [1:0] osc_cnt;
	// Open drain with pull-up, either party pulls low
	assign rst_pin_n_i = !(pin_low || rst_pin_oe);
	// Oscillator needs a few cycles to settle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			osc_cnt <= 2'h0;
		else if (osc_cnt != 2'h3)
			osc_cnt <= osc_cnt + 2'h1;
	end
	assign osc_stable = (osc_cnt == 2'h3);
endmodule

// *** sim/smrs_core_tb.sv ***
// Self-checking bench for the stop and reset-source block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("FAIL %s exp %h got %h", n, e, g); end end
module smrs_core_tb
	import smrs_pkg::*;
;
	logic       mclk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic       instr_done = 1'b0, irq_wake = 1'b0, supply_ok = 1'b0, mon_en = 1'b1;
	logic       closs = 1'b0, cmp = 1'b0, cnv_n = 1'b1, cnv_start, osc_stable, idle_mode;
	logic       rst_pin_n_i, rst_pin_o, rst_pin_oe, sys_rst, cpu_halt, osc_stop, exec_enable;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	int         bad_count = 0, check_count = 0, seed = 32'h429fc021, k, n;
	always #25 mclk = ~mclk;
	smrs_core #(.SUPPLY_TIMEOUT_CYC(20)) u_dut (.mclk, .arst_n, .sfr_wr, .sfr_rd, .sfr_addr,
		.sfr_wdata, .sfr_rdata, .instr_done, .irq_wake, .supply_ok,
		.supply_monitor_enable_pin(mon_en), .rst_pin_n_i, .clock_loss_trip(closs),
		.comparator_below(cmp), .convert_start_input_n(cnv_n), .osc_stable, .rst_pin_o,
		.rst_pin_oe, .sys_rst, .cpu_halt, .osc_stop, .idle_mode, .port_latch_force(),
		.irq_timer_disable(), .exec_enable, .reset_exit(), .second_converter_start(cnv_start));
	smrs_ext_model u_ext (.mclk, .arst_n, .rst_pin_oe, .rst_pin_n_i, .osc_stable);
	// ====
	// Flag bit that a source leaves behind
	function automatic logic [7:0] exp_flag(int s);
		return 8'h01 << ((s == 0) ? SMRS_RS_PIN_BIT : (s == 1) ? SMRS_RS_CLOSS_BIT :
			(s == 2) ? SMRS_RS_CMP_BIT : SMRS_RS_CNV_BIT);
	endfunction
	task automatic tick(int c);
		repeat (c) @(negedge mclk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		tick(1);
		`CHK("rdata", e, sfr_rdata)
	endtask
	// Bounded wait for the block to run again
	task automatic wait_run();
		n = 0;
		while (sys_rst !== 1'b0 && n < 300) begin
			tick(1);
			n++;
		end
		if (n >= 300) bad_count++;
	endtask
	// Enable a source, stop, then fire that source
	task automatic hit(int s);
		wr(SMRS_ADDR_RESET_SOURCE, (s == 0) ? 8'h00 : exp_flag(s));
		tick(1); // Strobe stays low one edge between writes
		wr(SMRS_ADDR_POWER_MODE, 8'h02 | (8'($random(seed)) & 8'hfc));
		instr_done = 1'b1;
		tick(1);
		instr_done = 1'b0;
		irq_wake = 1'b1;
		tick(2);
		`CHK("stop", 3'b110, {osc_stop, cpu_halt, exec_enable})
		irq_wake = 1'b0;
		{u_ext.pin_low, closs, cmp, cnv_n} = 4'b0001 ^ (4'b1000 >> s);
		tick(4 + ($random(seed) & 7));
		`CHK("enter", 2'b10, {sys_rst, rst_pin_oe})
		if (s == 3) `CHK("cnvstart", 1'b0, cnv_start)
		{u_ext.pin_low, closs, cmp, cnv_n} = 4'b0001;
		wait_run();
		`CHK("hold", 1'b1, n >= 12)
		rd(SMRS_ADDR_RESET_SOURCE, exp_flag(s));
		rd(SMRS_ADDR_POWER_MODE, 8'h00);
		rd(8'($random(seed)) & 8'h3f, 8'h00);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ====
	// Main sequence
	initial begin
		tick(6);
		arst_n = 1'b1;
		tick(3);
		supply_ok = 1'b1;
		wait_run();
		rd(SMRS_ADDR_RESET_SOURCE, 8'h02);
		{cmp, cnv_n} = 2'b10;
		tick(5);
		`CHK("disabled", 2'b01, {sys_rst, cnv_start})
		{cmp, cnv_n} = 2'b01;
		// Idle halts the processor only; an interrupt ends it
		wr(SMRS_ADDR_POWER_MODE, 8'h01);
		instr_done = 1'b1;
		tick(1);
		instr_done = 1'b0;
		tick(1);
		`CHK("idle", 3'b110, {idle_mode, cpu_halt, osc_stop})
		irq_wake = 1'b1;
		tick(2);
		`CHK("wake", 3'b001, {idle_mode, cpu_halt, exec_enable})
		irq_wake = 1'b0;
		for (k = 0; k < 12; k++) hit((k < 4) ? k : ($random(seed) & 3));
		mon_en = 1'b0;
		supply_ok = 1'b0;
		tick(6);
		`CHK("nomon", 1'b0, sys_rst)
		mon_en = 1'b1;
		tick(6);
		`CHK("drop", 2'b11, {sys_rst, rst_pin_oe})
		supply_ok = 1'b1;
		wait_run();
		rd(SMRS_ADDR_RESET_SOURCE, 8'h02);
		print_verdict();
	end
	// Watchdog, far beyond the expected run length
	initial begin
		#2_000_000;
		bad_count++;
		print_verdict();
	end
endmodule
